//--- design/dur_pkg.sv
// package for the two-channel serial register decode block
// assumes one host bus shared by both channels, one chip select each
package dur_pkg;

  // register offsets inside one channel, three address lines
  localparam logic [2:0] ADR_HOLD = 3'h0;  // holding / divisor low / trigger
  localparam logic [2:0] ADR_IER  = 3'h1;  // int enable / divisor high / feature
  localparam logic [2:0] ADR_ISR  = 3'h2;  // int status / fraction / enhanced fn
  localparam logic [2:0] ADR_LCR  = 3'h3;  // line control, always visible
  localparam logic [2:0] ADR_MCR  = 3'h4;  // modem control / resume 1
  localparam logic [2:0] ADR_LSR  = 3'h5;  // line status / resume 2
  localparam logic [2:0] ADR_MSR  = 3'h6;  // modem status / pause 1
  localparam logic [2:0] ADR_SPR  = 3'h7;  // scratch / level / pause 2

  // bank selection values and bit positions
  localparam logic [7:0] LCR_ENH_KEY   = 8'hBF;  // value that opens the enhanced bank
  localparam int         LCR_DIV_BIT   = 7;      // divisor access bit
  localparam int         EFR_ENH_BIT   = 4;      // enhanced bits enable
  localparam int         FEATURE_CONTROL_SWAP_BIT = 6;      // scratch / level swap
  localparam int         MCR_LOOP_BIT  = 4;      // internal loopback
  localparam int         ENHANCED_MODE_SELECT_CNT_BIT  = 0;      // level count select, 0 rx, 1 tx

  // masks of bits that only the enhanced enable unlocks
  localparam logic [7:0] ENH_IER_MASK = 8'hF0;
  localparam logic [7:0] ENH_ISR_MASK = 8'h30;
  localparam logic [7:0] ENH_FCR_MASK = 8'h30;
  localparam logic [7:0] ENH_MCR_MASK = 8'hE0;
  localparam logic [7:0] DLD_MASK     = 8'h0F;  // fraction is four bits wide

  // reset values and constant read values
  localparam logic [7:0] REG_RST   = 8'h00;   // every writable register
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] CHAR_BASE = 4'h5;    // shortest character length
  localparam logic [7:0] REV_CODE  = 8'h21;   // arbitrary value
  localparam logic [7:0] ID_CODE   = 8'h5C;   // arbitrary value

  // register selected by the decode
  typedef enum logic [4:0] {
    SEL_HOLD  = 5'h00, SEL_DLL  = 5'h01, SEL_DLM   = 5'h02, SEL_DLD   = 5'h03,
    SEL_IER   = 5'h04, SEL_ISR  = 5'h05, SEL_LCR   = 5'h06, SEL_MCR   = 5'h07,
    SEL_LSR   = 5'h08, SEL_MSR  = 5'h09, SEL_SPR   = 5'h0A, SEL_LVL   = 5'h0B,
    SEL_TRG   = 5'h0C, SEL_FEATURE_CONTROL = 5'h0D, SEL_EFR   = 5'h0E, SEL_XON1  = 5'h0F,
    SEL_XON2  = 5'h10, SEL_XOFF1 = 5'h11, SEL_XOFF2 = 5'h12
  } dur_sel_t;

endpackage

//--- design/dur_regs.sv
// register bank and address decode for both channels of the serial block
// assumes bus strobes and status inputs are synchronous to sys_clk and that
// a strobe stays high for one cycle per access
//
// Functional notes
// - each channel own registers via its select
// - offset 0 holding bytes when divisor access off
// - divisor access maps offsets 0,1 to divisor
// - enhanced bits and fraction need enhanced enable
// - zero divisor reads revision and identification codes
// - offset 1 interrupt enable when divisor off
// - offset 2 status read, queue control write
// - offset 3 always line control
// - offset 4 modem control in normal bank
// - offset 5 read-only line status
// - offset 6 read-only modem status
// - offset 7 scratch when swap bit clear
// - offset 7 reads level when swap set
// - offset 7 writes mode select when swap set
// - enhanced offset 0 trigger write, count read
// - enhanced offset 1 feature control
// - enhanced offset 2 enhanced function
// - enhanced offsets 4-7 resume and pause characters
// - line control low bits set character length
// - modem control loopback ties transmit to receive
`timescale 1ns/100ps

module dur_regs
  import dur_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // host bus
  input  wire logic [2:0]       bus_addr,
  input  wire logic             chan_a_select_n,
  input  wire logic             chan_b_select_n,
  input  wire logic             bus_rd,
  input  wire logic             bus_wr,
  input  wire logic [7:0]       bus_wdata,
  output logic      [7:0]       bus_rdata,
  // status from each channel core
  input  wire logic [1:0][7:0]  rx_data,
  input  wire logic [1:0][7:0]  isr_in,
  input  wire logic [1:0][7:0]  lsr_in,
  input  wire logic [1:0][3:0]  modem_lvl,
  input  wire logic [1:0][3:0]  modem_delta,
  input  wire logic [1:0][7:0]  rx_level,
  input  wire logic [1:0][7:0]  tx_level,
  // serial data for loopback
  input  wire logic [1:0]       tx_serial,
  input  wire logic [1:0]       rx_pin,
  output logic      [1:0]       rx_serial,
  // access pulses and write data to each channel core
  output logic      [1:0]       rx_pop,
  output logic      [1:0]       tx_push,
  output logic      [1:0]       qctl_wr,
  output logic      [1:0]       trg_wr,
  output logic      [1:0]       isr_rd,
  output logic      [1:0]       lsr_rd,
  output logic      [1:0]       msr_rd,
  output logic      [7:0]       wr_data,
  output logic      [7:0]       qctl_data,
  // configuration to each channel core
  output logic      [1:0][7:0]  lcr_out,
  output logic      [1:0][7:0]  ier_out,
  output logic      [1:0][7:0]  mcr_out,
  output logic      [1:0][7:0]  dll_out,
  output logic      [1:0][7:0]  dlm_out,
  output logic      [1:0][7:0]  dld_out,
  output logic      [1:0][7:0]  efr_out,
  output logic      [1:0][7:0]  feature_control_out,
  output logic      [1:0][7:0]  enhanced_mode_select_out,
  output logic      [1:0][7:0]  trg_out,
  output logic      [1:0][7:0]  xon1_out,
  output logic      [1:0][7:0]  xon2_out,
  output logic      [1:0][7:0]  xoff1_out,
  output logic      [1:0][7:0]  xoff2_out,
  output logic      [1:0][3:0]  char_bits,
  output logic      [1:0]       loop_en
);

  ////////////////////////////////////////////////////////////////////////////
  // state and functions

  typedef struct packed {
    logic [1:0][7:0] line_control;      // line control
    logic [1:0][7:0] interrupt_enable;      // interrupt enable
    logic [1:0][7:0] modem_control;      // modem control
    logic [1:0][7:0] dll;      // divisor low
    logic [1:0][7:0] divisor_high;      // divisor high
    logic [1:0][7:0] divisor_fraction;      // divisor fraction
    logic [1:0][7:0] enhanced_function;      // enhanced function
    logic [1:0][7:0] feature_control;     // feature control
    logic [1:0][7:0] scratch;      // scratch
    logic [1:0][7:0] enhanced_mode_select;     // enhanced mode select
    logic [1:0][7:0] fifo_trigger_write;      // trigger level
    logic [1:0][7:0] xon1;     // resume characters
    logic [1:0][7:0] xon2;
    logic [1:0][7:0] xoff1;    // pause characters
    logic [1:0][7:0] xoff2;
    logic [1:0][3:0] chr;      // character length in bits
    logic [7:0]      rdata;    // read data, held until next read
    logic [7:0]      wdata;    // last write data
    logic [7:0]      qdata;    // last queue control write, masked
    logic [1:0]      rx_pop;   // one-cycle access pulses
    logic [1:0]      tx_push;
    logic [1:0]      qctl_wr;
    logic [1:0]      trg_wr;
    logic [1:0]      isr_rd;
    logic [1:0]      lsr_rd;
    logic [1:0]      msr_rd;
    logic [1:0]      rx_ser;   // receive serial after loopback mux
  } dur_state_t;

  dur_state_t st_ff;           // registered state
  dur_state_t nxt_st;          // next state
  logic [1:0] rst_sync_ff;     // reset release synchroniser
  logic       rst_n;           // synchronised reset
  logic       ch;              // selected channel, 0 is a, 1 is b
  logic       acc_ok;          // exactly one channel selected
  dur_sel_t   sel;             // decoded register

  // decode offset and bank state into a register
  function automatic dur_sel_t dur_decode(input logic [2:0] a, input logic [7:0] line_control,
                                          input logic efr4, input logic swap);
    logic enh;
    logic div;
    enh = (line_control == LCR_ENH_KEY);
    div = line_control[LCR_DIV_BIT];
    unique case (a)
      ADR_HOLD: dur_decode = enh ? SEL_TRG : (div ? SEL_DLL : SEL_HOLD);
      ADR_IER:  dur_decode = enh ? SEL_FEATURE_CONTROL : (div ? SEL_DLM : SEL_IER);
      ADR_ISR:  dur_decode = enh ? SEL_EFR :
                             ((div && efr4) ? SEL_DLD : SEL_ISR);
      ADR_LCR:  dur_decode = SEL_LCR;
      ADR_MCR:  dur_decode = enh ? SEL_XON1 : SEL_MCR;
      ADR_LSR:  dur_decode = enh ? SEL_XON2 : SEL_LSR;
      ADR_MSR:  dur_decode = enh ? SEL_XOFF1 : SEL_MSR;
      ADR_SPR:  dur_decode = enh ? SEL_XOFF2 : (swap ? SEL_LVL : SEL_SPR);
    endcase
  endfunction

  // keep locked enhanced bits at their old value unless unlocked
  function automatic logic [7:0] dur_gate(input logic [7:0] nv, input logic [7:0] ov,
                                          input logic [7:0] mask, input logic en);
    dur_gate = en ? nv : ((ov & mask) | (nv & ~mask));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  // two-stage release of the asynchronous reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // decode and next state

  // one select low picks the channel, both low is refused
  assign acc_ok = chan_a_select_n ^ chan_b_select_n;
  assign ch     = chan_a_select_n;
  assign sel    = dur_decode(bus_addr, st_ff.line_control[ch], st_ff.enhanced_function[ch][EFR_ENH_BIT],
                             st_ff.feature_control[ch][FEATURE_CONTROL_SWAP_BIT]);

  // register writes, read data capture and access pulses
  always_comb begin
    logic efr4;
    logic dzero;
    efr4    = st_ff.enhanced_function[ch][EFR_ENH_BIT];
    dzero   = (st_ff.dll[ch] == ZERO_BYTE) && (st_ff.divisor_high[ch] == ZERO_BYTE);
    nxt_st  = st_ff;
    // pulses last one cycle
    nxt_st.rx_pop  = 2'h0;
    nxt_st.tx_push = 2'h0;
    nxt_st.qctl_wr = 2'h0;
    nxt_st.trg_wr  = 2'h0;
    nxt_st.isr_rd  = 2'h0;
    nxt_st.lsr_rd  = 2'h0;
    nxt_st.msr_rd  = 2'h0;
    if (acc_ok && bus_wr) begin
      // write path, a write wins over a read in the same cycle
      nxt_st.wdata = bus_wdata;
      unique case (sel)
        SEL_HOLD: nxt_st.tx_push[ch] = 1'b1;
        SEL_DLL:  nxt_st.dll[ch] = bus_wdata;
        SEL_DLM:  nxt_st.divisor_high[ch] = bus_wdata;
        SEL_DLD:  nxt_st.divisor_fraction[ch] = bus_wdata & DLD_MASK;
        SEL_IER:  nxt_st.interrupt_enable[ch] = dur_gate(bus_wdata, st_ff.interrupt_enable[ch],
                                            ENH_IER_MASK, efr4);
        SEL_ISR: begin
          // queue control is write-only, locked bits go out as zero
          nxt_st.qctl_wr[ch] = 1'b1;
          nxt_st.qdata = dur_gate(bus_wdata, ZERO_BYTE, ENH_FCR_MASK, efr4);
        end
        SEL_LCR:  nxt_st.line_control[ch] = bus_wdata;
        SEL_MCR:  nxt_st.modem_control[ch] = dur_gate(bus_wdata, st_ff.modem_control[ch],
                                            ENH_MCR_MASK, efr4);
        SEL_SPR:  nxt_st.scratch[ch] = bus_wdata;
        SEL_LVL:  nxt_st.enhanced_mode_select[ch] = bus_wdata;
        SEL_TRG: begin
          nxt_st.fifo_trigger_write[ch]    = bus_wdata;
          nxt_st.trg_wr[ch] = 1'b1;
        end
        SEL_FEATURE_CONTROL:  nxt_st.feature_control[ch]  = bus_wdata;
        SEL_EFR:   nxt_st.enhanced_function[ch]   = bus_wdata;
        SEL_XON1:  nxt_st.xon1[ch]  = bus_wdata;
        SEL_XON2:  nxt_st.xon2[ch]  = bus_wdata;
        SEL_XOFF1: nxt_st.xoff1[ch] = bus_wdata;
        SEL_XOFF2: nxt_st.xoff2[ch] = bus_wdata;
        // status registers ignore writes
        SEL_LSR, SEL_MSR: nxt_st.wdata = bus_wdata;
      endcase
    end else if (acc_ok && bus_rd) begin
      // read path, data stands until the next read
      unique case (sel)
        SEL_HOLD: begin
          nxt_st.rdata = rx_data[ch];
          nxt_st.rx_pop[ch] = 1'b1;
        end
        SEL_DLL:  nxt_st.rdata = dzero ? REV_CODE : st_ff.dll[ch];
        SEL_DLM:  nxt_st.rdata = dzero ? ID_CODE : st_ff.divisor_high[ch];
        SEL_DLD:  nxt_st.rdata = st_ff.divisor_fraction[ch];
        SEL_IER:  nxt_st.rdata = st_ff.interrupt_enable[ch];
        SEL_ISR: begin
          nxt_st.rdata = dur_gate(isr_in[ch], ZERO_BYTE, ENH_ISR_MASK, efr4);
          nxt_st.isr_rd[ch] = 1'b1;
        end
        SEL_LCR:  nxt_st.rdata = st_ff.line_control[ch];
        SEL_MCR:  nxt_st.rdata = st_ff.modem_control[ch];
        SEL_LSR: begin
          nxt_st.rdata = lsr_in[ch];
          nxt_st.lsr_rd[ch] = 1'b1;
        end
        SEL_MSR: begin
          nxt_st.rdata = {modem_lvl[ch], modem_delta[ch]};
          nxt_st.msr_rd[ch] = 1'b1;
        end
        SEL_SPR:  nxt_st.rdata = st_ff.scratch[ch];
        SEL_LVL, SEL_TRG: begin
          // level count of the queue picked by mode select
          nxt_st.rdata = st_ff.enhanced_mode_select[ch][ENHANCED_MODE_SELECT_CNT_BIT] ? tx_level[ch]
                                                      : rx_level[ch];
        end
        SEL_FEATURE_CONTROL:  nxt_st.rdata = st_ff.feature_control[ch];
        SEL_EFR:   nxt_st.rdata = st_ff.enhanced_function[ch];
        SEL_XON1:  nxt_st.rdata = st_ff.xon1[ch];
        SEL_XON2:  nxt_st.rdata = st_ff.xon2[ch];
        SEL_XOFF1: nxt_st.rdata = st_ff.xoff1[ch];
        SEL_XOFF2: nxt_st.rdata = st_ff.xoff2[ch];
      endcase
    end
    // per-channel derived settings
    for (int i = 0; i < 2; i++) begin
      nxt_st.chr[i]    = CHAR_BASE + {2'h0, nxt_st.line_control[i][1:0]};
      nxt_st.rx_ser[i] = st_ff.modem_control[i][MCR_LOOP_BIT] ? tx_serial[i]
                                                     : rx_pin[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // all state but the reset synchroniser in one register, cleared on reset except character length, which loads CHAR_BASE
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff     <= '0;
      st_ff.chr <= {CHAR_BASE, CHAR_BASE};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign bus_rdata = st_ff.rdata;
  assign rx_serial = st_ff.rx_ser;
  assign rx_pop    = st_ff.rx_pop;
  assign tx_push   = st_ff.tx_push;
  assign qctl_wr   = st_ff.qctl_wr;
  assign trg_wr    = st_ff.trg_wr;
  assign isr_rd    = st_ff.isr_rd;
  assign lsr_rd    = st_ff.lsr_rd;
  assign msr_rd    = st_ff.msr_rd;
  assign wr_data   = st_ff.wdata;
  assign qctl_data = st_ff.qdata;
  assign lcr_out   = st_ff.line_control;
  assign ier_out   = st_ff.interrupt_enable;
  assign mcr_out   = st_ff.modem_control;
  assign dll_out   = st_ff.dll;
  assign dlm_out   = st_ff.divisor_high;
  assign dld_out   = st_ff.divisor_fraction;
  assign efr_out   = st_ff.enhanced_function;
  assign feature_control_out  = st_ff.feature_control;
  assign enhanced_mode_select_out  = st_ff.enhanced_mode_select;
  assign trg_out   = st_ff.fifo_trigger_write;
  assign xon1_out  = st_ff.xon1;
  assign xon2_out  = st_ff.xon2;
  assign xoff1_out = st_ff.xoff1;
  assign xoff2_out = st_ff.xoff2;
  assign char_bits = st_ff.chr;
  assign loop_en   = {st_ff.modem_control[1][MCR_LOOP_BIT], st_ff.modem_control[0][MCR_LOOP_BIT]};

  ////////////////////////////////////////////////////////////////////////////
  // checks on channel a accesses, and one cover of a channel b write

  logic a_wr;   // write to channel a
  logic a_rd;   // read of channel a
  logic a_norm; // channel a in normal bank, divisor access off
  logic a_div;  // channel a divisor access, not the enhanced key
  assign a_wr   = bus_wr && !chan_a_select_n && chan_b_select_n;
  assign a_rd   = bus_rd && !bus_wr && !chan_a_select_n && chan_b_select_n;
  assign a_norm = !st_ff.line_control[0][LCR_DIV_BIT];
  assign a_div  = st_ff.line_control[0][LCR_DIV_BIT] && (st_ff.line_control[0] != LCR_ENH_KEY);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chan_isolate_a: assert property (a_wr |=> $stable(st_ff.line_control[1]))
    else $error("channel b changed on channel a write");
  hold_push_a: assert property (a_wr && a_norm && bus_addr == ADR_HOLD
    |=> tx_push == 2'h1 ##1 tx_push == 2'h0)
    else $error("holding write did not give one push pulse");
  div_write_a: assert property (a_wr && a_div && bus_addr == ADR_IER
    |=> dlm_out[0] == $past(bus_wdata))
    else $error("divisor high not loaded");
  dld_lock_a: assert property (a_wr && a_div && !st_ff.enhanced_function[0][EFR_ENH_BIT]
    && bus_addr == ADR_ISR |=> $stable(dld_out[0]) && qctl_wr[0])
    else $error("fraction written while locked");
  rev_read_a: assert property (a_rd && a_div && bus_addr == ADR_HOLD && dll_out[0] == ZERO_BYTE
    && dlm_out[0] == ZERO_BYTE |=> bus_rdata == REV_CODE)
    else $error("revision code not returned");
  ier_lock_a: assert property (a_wr && a_norm && bus_addr == ADR_IER
    && !st_ff.enhanced_function[0][EFR_ENH_BIT] |=> ier_out[0][7:4] == $past(ier_out[0][7:4]))
    else $error("locked enable bits changed");
  isr_read_a: assert property (a_rd && a_norm && bus_addr == ADR_ISR
    |=> isr_rd[0] && bus_rdata[3:0] == $past(isr_in[0][3:0]))
    else $error("status read wrong");
  lcr_write_a: assert property (a_wr && bus_addr == ADR_LCR
    |=> lcr_out[0] == $past(bus_wdata) ##1 char_bits[0] == CHAR_BASE + {2'h0, lcr_out[0][1:0]})
    else $error("line control or length wrong");
  msr_read_a: assert property (a_rd && a_norm && bus_addr == ADR_MSR
    |=> bus_rdata == {$past(modem_lvl[0]), $past(modem_delta[0])})
    else $error("modem status read wrong");
  lvl_read_a: assert property (a_rd && st_ff.line_control[0] != LCR_ENH_KEY && bus_addr == ADR_SPR
    && st_ff.feature_control[0][FEATURE_CONTROL_SWAP_BIT] && !st_ff.enhanced_mode_select[0][ENHANCED_MODE_SELECT_CNT_BIT]
    |=> bus_rdata == $past(rx_level[0]))
    else $error("level count read wrong");
  xon_write_a: assert property (a_wr && st_ff.line_control[0] == LCR_ENH_KEY && bus_addr == ADR_MCR
    |=> xon1_out[0] == $past(bus_wdata) && $stable(mcr_out[0]))
    else $error("resume char write wrong");
  loop_path_a: assert property (loop_en[0] |=> rx_serial[0] == $past(tx_serial[0]))
    else $error("loopback path broken");

  enh_bank_c: cover property (a_wr && bus_addr == ADR_LCR && bus_wdata == LCR_ENH_KEY);
  div_read_c: cover property (a_rd && a_div && bus_addr == ADR_HOLD);
  chan_b_c:   cover property (bus_wr && chan_a_select_n && !chan_b_select_n);
  swap_c:     cover property (a_wr && st_ff.feature_control[0][FEATURE_CONTROL_SWAP_BIT] && bus_addr == ADR_SPR);

endmodule

//--- tb/dur_core_model.sv
// stand-in for the two channel cores that face the register block
// assumes fixed, distinct status values per channel are enough for decode checks
`timescale 1ns/100ps

module dur_core_model (
  // status bytes toward the register block
  output logic [1:0][7:0] rx_data,
  output logic [1:0][7:0] isr_in,
  output logic [1:0][7:0] lsr_in,
  output logic [1:0][3:0] modem_lvl,
  output logic [1:0][3:0] modem_delta,
  output logic [1:0][7:0] rx_level,
  output logic [1:0][7:0] tx_level,
  // serial bits, opposite levels so loopback shows
  output logic [1:0]      tx_serial,
  output logic [1:0]      rx_pin
);
  ////////////////////////////////////////////////////////////////////////
  // every channel gets its own pattern so a crossed decode is caught
  assign rx_data     = {8'h5A, 8'hC3};
  assign isr_in      = {8'h3E, 8'hF1};
  assign lsr_in      = {8'h61, 8'h9E};
  assign modem_lvl   = {4'h3, 4'hA};
  assign modem_delta = {4'hC, 4'h6};
  assign rx_level    = {8'h11, 8'h2B};
  assign tx_level    = {8'h22, 8'h3D};
  assign tx_serial   = 2'h1;
  assign rx_pin      = 2'h2;
endmodule

//--- tb/testbench.sv
// self-checking bench for the serial register decode block
// assumes one access per strobe and read data registered on the taking edge
`timescale 1ns/100ps

module testbench
  import dur_pkg::*;
;
  localparam logic [1:0] CA = 2'h2;  // select_n {b,a}: channel a
  localparam logic [1:0] CB = 2'h1;  // channel b
  localparam logic [1:0] NO = 2'h0;  // both selected, must be ignored
  logic sys_clk = 1'b0, nrst = 1'b0, bus_rd = 1'b0, bus_wr = 1'b0;
  logic chan_a_select_n = 1'b1, chan_b_select_n = 1'b1;
  logic [2:0] bus_addr = 3'h0;
  logic [7:0] bus_wdata = 8'h00, bus_rdata, qctl_data, got;
  logic [1:0][7:0] rx_data, isr_in, lsr_in, rx_level, tx_level;
  logic [1:0][7:0] lcr_out, dll_out, dld_out, enhanced_mode_select_out, trg_out;
  logic [1:0][3:0] modem_lvl, modem_delta, char_bits;
  logic [1:0] tx_serial, rx_pin, rx_serial, rx_pop, tx_push, qctl_wr, loop_en, pop_s, push_s;
  int n_mismatch = 0, comparisons = 0, i;

  always #4 sys_clk = ~sys_clk;

  dur_core_model u_dur_core_model (.rx_data(rx_data), .isr_in(isr_in), .lsr_in(lsr_in),
    .modem_lvl(modem_lvl), .modem_delta(modem_delta), .rx_level(rx_level),
    .tx_level(tx_level), .tx_serial(tx_serial), .rx_pin(rx_pin));

  dur_regs u_dur_regs (.sys_clk(sys_clk), .nrst(nrst), .bus_addr(bus_addr),
    .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .rx_data(rx_data),
    .isr_in(isr_in), .lsr_in(lsr_in), .modem_lvl(modem_lvl), .modem_delta(modem_delta),
    .rx_level(rx_level), .tx_level(tx_level), .tx_serial(tx_serial), .rx_pin(rx_pin),
    .rx_serial(rx_serial), .rx_pop(rx_pop), .tx_push(tx_push), .qctl_wr(qctl_wr), .trg_wr(),
    .isr_rd(), .lsr_rd(), .msr_rd(), .wr_data(), .qctl_data(qctl_data), .lcr_out(lcr_out),
    .ier_out(), .mcr_out(), .dll_out(dll_out), .dlm_out(), .dld_out(dld_out), .efr_out(),
    .feature_control_out(), .enhanced_mode_select_out(enhanced_mode_select_out), .trg_out(trg_out), .xon1_out(), .xon2_out(),
    .xoff1_out(), .xoff2_out(), .char_bits(char_bits), .loop_en(loop_en));

  ////////////////////////////////////////////////////////////////////////
  // one strobe cycle, then sample data and pulses on the falling edge after taking
  task automatic acc(input logic [1:0] sel, input logic w, input logic [2:0] a,
                     input logic [7:0] d);
    @(posedge sys_clk);
    {chan_b_select_n, chan_a_select_n} <= sel;
    bus_addr <= a;
    bus_wr <= w;
    bus_rd <= ~w;
    bus_wdata <= d;
    @(posedge sys_clk);
    {chan_b_select_n, chan_a_select_n} <= 2'h3;
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    @(negedge sys_clk);
    got = bus_rdata;
    pop_s = rx_pop;
    push_s = tx_push;
  endtask

  // byte compare, counts and reports
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // cut a hang short, far beyond the hundred or so cycles of the sequence
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("char_bits_rst", 8'h05, {4'h0, char_bits[0]});
    acc(CA, 1, ADR_LCR, 8'h80);
    acc(CA, 0, ADR_HOLD, 8'h00); chk("rev", REV_CODE, got);
    acc(CA, 0, ADR_IER, 8'h00); chk("id", ID_CODE, got);
    acc(CA, 1, ADR_HOLD, 8'h12);
    acc(CA, 1, ADR_IER, 8'h34);
    acc(CA, 0, ADR_HOLD, 8'h00); chk("dll", 8'h12, got);
    acc(CA, 0, ADR_IER, 8'h00); chk("dlm", 8'h34, got);
    chk("dll_b", 8'h00, dll_out[1]);
    acc(CA, 1, ADR_ISR, 8'hFF); chk("qctl", 8'hCF, qctl_data);
    chk("dld_locked", 8'h00, dld_out[0]);
    acc(CA, 1, ADR_LCR, 8'h03); chk("char_bits", 8'h08, {4'h0, char_bits[0]});
    acc(CA, 0, ADR_HOLD, 8'h00); chk("rx_hold", rx_data[0], got);
    chk("pop", 8'h01, {6'h0, pop_s});
    acc(CA, 1, ADR_HOLD, 8'h77); chk("push", 8'h01, {6'h0, push_s});
    acc(CA, 1, ADR_IER, 8'hFF);
    acc(CA, 0, ADR_IER, 8'h00); chk("ier_lock", 8'h0F, got);
    acc(CA, 0, ADR_ISR, 8'h00); chk("isr", isr_in[0] & ~ENH_ISR_MASK, got);
    acc(CA, 1, ADR_LSR, 8'hAA);
    acc(CA, 0, ADR_LSR, 8'h00); chk("lsr", lsr_in[0], got);
    acc(CA, 0, ADR_MSR, 8'h00); chk("msr", {modem_lvl[0], modem_delta[0]}, got);
    acc(CA, 1, ADR_MCR, 8'hF0);
    acc(CA, 0, ADR_MCR, 8'h00); chk("mcr", 8'h10, got);
    chk("loop", {7'h0, tx_serial[0]}, {7'h0, rx_serial[0]});
    acc(CA, 1, ADR_SPR, 8'hA5);
    acc(CA, 0, ADR_SPR, 8'h00); chk("scratch", 8'hA5, got);
    acc(CA, 1, ADR_LCR, LCR_ENH_KEY);
    acc(CA, 0, ADR_LCR, 8'h00); chk("lcr", LCR_ENH_KEY, got);
    for (i = 0; i < 4; i++) begin
      acc(CA, 1, ADR_MCR + 3'(i), 8'hE0 + 8'(i));
      acc(CA, 0, ADR_MCR + 3'(i), 8'h00); chk("flow_char", 8'hE0 + 8'(i), got);
    end
    acc(CA, 1, ADR_ISR, 8'h10);
    acc(CA, 0, ADR_ISR, 8'h00); chk("efr", 8'h10, got);
    acc(CA, 1, ADR_IER, 8'h40);
    acc(CA, 0, ADR_IER, 8'h00); chk("feature_control", 8'h40, got);
    acc(CA, 1, ADR_HOLD, 8'h20); chk("trg", 8'h20, trg_out[0]);
    acc(CA, 0, ADR_HOLD, 8'h00); chk("count", rx_level[0], got);
    acc(CA, 1, ADR_LCR, 8'h03);
    acc(CA, 1, ADR_IER, 8'hFF);
    acc(CA, 0, ADR_IER, 8'h00); chk("ier_open", 8'hFF, got);
    acc(CA, 1, ADR_SPR, 8'h01); chk("enhanced_mode_select", 8'h01, enhanced_mode_select_out[0]);
    acc(CA, 0, ADR_SPR, 8'h00); chk("level", tx_level[0], got);
    acc(NO, 1, ADR_LCR, 8'h55); chk("both_sel", 8'h03, lcr_out[0]);
    chk("lcr_b", 8'h00, lcr_out[1]);
    acc(CB, 1, ADR_SPR, 8'h3C);
    acc(CB, 0, ADR_SPR, 8'h00); chk("scratch_b", 8'h3C, got);
    acc(CB, 0, ADR_HOLD, 8'h00); chk("rx_hold_b", rx_data[1], got);
    chk("pop_b", 8'h02, {6'h0, pop_s});
    report_and_stop;
  end
endmodule
